// ===== hdl/phm_regs.svh
// Register map and fixed values of the peripheral hardware multiplier.
// Assumes byte addresses on a 16-bit CPU peripheral bus, word aligned.
`ifndef PHM_REGS_SVH
`define PHM_REGS_SVH

`define PHM_ADDR_UNSIGNED_PRODUCT    16'h0130
`define PHM_ADDR_SIGNED_PRODUCT      16'h0132
`define PHM_ADDR_UNSIGNED_ACCUMULATE 16'h0134
`define PHM_ADDR_SIGNED_ACCUMULATE   16'h0136
`define PHM_ADDR_SECOND_OPERAND      16'h0138
`define PHM_ADDR_RESULT_LOW          16'h013a
`define PHM_ADDR_RESULT_HIGH         16'h013c
`define PHM_ADDR_RESULT_SUM_EXT      16'h013e

`define PHM_RESET_WORD               16'h0000
`define PHM_RESET_PRODUCT            32'h0000_0000
`define PHM_BYTE_SIGN_BIT            7

`endif

// ===== hdl/phm_pkg.sv
// Types shared by the peripheral hardware multiplier.
// Assumes nothing beyond a SystemVerilog elaborator.
package phm_pkg;

    typedef enum logic [1:0] {
        PHM_UNSIGNED_PRODUCT,
        PHM_SIGNED_PRODUCT,
        PHM_UNSIGNED_ACCUMULATE,
        PHM_SIGNED_ACCUMULATE
    } phm_mode_t;

    // One CPU peripheral access, valid for the cycle it is presented.
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        write;
        logic        read;
        logic        byte_acc;
    } phm_req_t;

    typedef struct packed {
        logic [15:0] high;
        logic [15:0] low;
        logic [15:0] ext;
    } phm_result_t;

endpackage : phm_pkg

// ===== hdl/phm_top.sv
// Peripheral hardware multiplier with multiply and accumulate modes.
// Assumes a CPU on the same clock presenting one access per cycle.
//
// What this block does
// - Address of first operand write selects one of four operations.
// - First operand write only stores operand and mode, starts nothing.
// - Second operand write launches latched operation with stored operand.
// - Results complete three clock cycles after second operand write.
// - Two 16-bit operand registers and three result registers exist.
// - First operand persists; each second operand write repeats the mode.
// - Accepts 16x16, 16x8, 8x16 and 8x8 operands in every mode.
// - All three result registers update together on completion.
// - Low result word always gets bits 15 to 0 of result.
// - Unsigned modes put upper 16 result bits in high word.
// - Signed multiply high word holds sign and upper 15 bits.
// - Signed accumulate high word holds upper 16 bits, two's complement.
// - Sum extension reads zero in unsigned multiply.
// - Signed modes put sign extension of result in sum extension.
// - Unsigned accumulate puts carry of 32-bit sum in sum extension.
// - Signed byte operands are sign-extended inside the unit.
`include "phm_regs.svh"

module phm_top (
    // Clock and reset.
    input  wire logic            sys_clk_in,
    input  wire logic            reset_in,
    // CPU peripheral access.
    input  wire phm_pkg::phm_req_t cpu_req_in,
    output logic [15:0]          cpu_rdata_out
);
    import phm_pkg::*;

    function automatic logic [15:0] widen(input logic [15:0] data,
                                          input logic        byte_acc,
                                          input logic        sgn);
        if (!byte_acc) begin
            widen = data;
        end else if (sgn) begin
            widen = {{8{data[`PHM_BYTE_SIGN_BIT]}}, data[7:0]};
        end else begin
            widen = {8'h00, data[7:0]};
        end
    endfunction : widen

    function automatic logic is_signed(input phm_mode_t m);
        is_signed = (m == PHM_SIGNED_PRODUCT) ||
                    (m == PHM_SIGNED_ACCUMULATE);
    endfunction : is_signed

    function automatic logic [31:0] multiply(input logic [15:0] a,
                                             input logic [15:0] b,
                                             input logic        sgn);
        logic [31:0] wa;
        logic [31:0] wb;
        wa = sgn ? {{16{a[15]}}, a} : {16'h0000, a};
        wb = sgn ? {{16{b[15]}}, b} : {16'h0000, b};
        multiply = wa * wb;
    endfunction : multiply

    logic        wr;
    logic        hit_first;
    logic        hit_second;
    logic        first_sgn;
    logic [15:0] second_val;
    phm_mode_t   mode_d;

    phm_mode_t   mode_q;
    logic [15:0] first_operand_q;
    logic [15:0] second_operand_q;
    logic        s1_valid_q;
    logic        s2_valid_q;
    phm_mode_t   s1_mode_q;
    phm_mode_t   s2_mode_q;
    logic [31:0] s1_prod_q;
    logic [31:0] s2_prod_q;
    phm_result_t res_d;
    phm_result_t res_q;
    logic [32:0] sum;
    logic [15:0] rdata_d;
    logic [15:0] rdata_q;

    assign wr = cpu_req_in.write;

    // Mode decode from the first operand address.
    always_comb begin
        hit_first = wr;
        first_sgn = 1'b0;
        mode_d    = PHM_UNSIGNED_PRODUCT;
        case (cpu_req_in.addr)
            `PHM_ADDR_UNSIGNED_PRODUCT: begin
                mode_d = PHM_UNSIGNED_PRODUCT;
            end
            `PHM_ADDR_SIGNED_PRODUCT: begin
                mode_d    = PHM_SIGNED_PRODUCT;
                first_sgn = 1'b1;
            end
            `PHM_ADDR_UNSIGNED_ACCUMULATE: begin
                mode_d = PHM_UNSIGNED_ACCUMULATE;
            end
            `PHM_ADDR_SIGNED_ACCUMULATE: begin
                mode_d    = PHM_SIGNED_ACCUMULATE;
                first_sgn = 1'b1;
            end
            default: begin
                hit_first = 1'b0;
            end
        endcase
    end

    assign hit_second = wr && (cpu_req_in.addr == `PHM_ADDR_SECOND_OPERAND);
    // A byte write to the second operand follows the latched signedness.
    assign second_val = widen(cpu_req_in.wdata, cpu_req_in.byte_acc,
                              is_signed(mode_q));

    // First operand and mode: stored only, no computation starts here.
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            first_operand_q <= `PHM_RESET_WORD;
            mode_q          <= PHM_UNSIGNED_PRODUCT;
        end else if (hit_first) begin
            first_operand_q <= widen(cpu_req_in.wdata, cpu_req_in.byte_acc,
                                     first_sgn);
            mode_q          <= mode_d;
        end
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            second_operand_q <= `PHM_RESET_WORD;
        end else if (hit_second) begin
            second_operand_q <= second_val;
        end
    end

    // Three-stage pipeline: product, delay, then accumulate and write back.
    // Accumulation reads the result registers in the write-back stage,
    // so launches on consecutive cycles chain without forwarding.
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            s1_valid_q <= 1'b0;
            s2_valid_q <= 1'b0;
            s1_mode_q  <= PHM_UNSIGNED_PRODUCT;
            s2_mode_q  <= PHM_UNSIGNED_PRODUCT;
            s1_prod_q  <= `PHM_RESET_PRODUCT;
            s2_prod_q  <= `PHM_RESET_PRODUCT;
        end else begin
            s1_valid_q <= hit_second;
            s1_mode_q  <= mode_q;
            s1_prod_q  <= multiply(first_operand_q, second_val,
                                   is_signed(mode_q));
            s2_valid_q <= s1_valid_q;
            s2_mode_q  <= s1_mode_q;
            s2_prod_q  <= s1_prod_q;
        end
    end

    always_comb begin
        sum   = {1'b0, res_q.high, res_q.low}
              + {1'b0, s2_prod_q};
        res_d = res_q;
        case (s2_mode_q)
            PHM_UNSIGNED_PRODUCT: begin
                {res_d.high, res_d.low} = s2_prod_q;
                res_d.ext = 16'h0000;
            end
            PHM_SIGNED_PRODUCT: begin
                {res_d.high, res_d.low} = s2_prod_q;
                res_d.ext = {16{s2_prod_q[31]}};
            end
            PHM_UNSIGNED_ACCUMULATE: begin
                {res_d.high, res_d.low} = sum[31:0];
                res_d.ext = {15'h0000, sum[32]};
            end
            PHM_SIGNED_ACCUMULATE: begin
                {res_d.high, res_d.low} = sum[31:0];
                res_d.ext = {16{sum[31]}};
            end
            default: begin
                res_d = res_q;
            end
        endcase
    end

    // Completion wins over a CPU write to a result word in the same cycle.
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            res_q <= '0;
        end else if (s2_valid_q) begin
            res_q <= res_d;
        end else if (wr) begin
            if (cpu_req_in.addr == `PHM_ADDR_RESULT_LOW) begin
                res_q.low <= widen(cpu_req_in.wdata, cpu_req_in.byte_acc,
                                   1'b0);
            end
            if (cpu_req_in.addr == `PHM_ADDR_RESULT_HIGH) begin
                res_q.high <= widen(cpu_req_in.wdata, cpu_req_in.byte_acc,
                                    1'b0);
            end
        end
    end

    // Read port: data is registered and valid the cycle after the strobe.
    always_comb begin
        rdata_d = 16'h0000;
        if (cpu_req_in.read) begin
            case (cpu_req_in.addr)
                `PHM_ADDR_UNSIGNED_PRODUCT:    rdata_d = first_operand_q;
                `PHM_ADDR_SIGNED_PRODUCT:      rdata_d = first_operand_q;
                `PHM_ADDR_UNSIGNED_ACCUMULATE: rdata_d = first_operand_q;
                `PHM_ADDR_SIGNED_ACCUMULATE:   rdata_d = first_operand_q;
                `PHM_ADDR_SECOND_OPERAND:      rdata_d = second_operand_q;
                `PHM_ADDR_RESULT_LOW:          rdata_d = res_q.low;
                `PHM_ADDR_RESULT_HIGH:         rdata_d = res_q.high;
                `PHM_ADDR_RESULT_SUM_EXT:      rdata_d = res_q.ext;
                default:                       rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            rdata_q <= `PHM_RESET_WORD;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign cpu_rdata_out = rdata_q;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);

    AST_MODE_SELECT:
    assert property (wr && cpu_req_in.addr == `PHM_ADDR_SIGNED_ACCUMULATE
                     |=> mode_q == PHM_SIGNED_ACCUMULATE)
        else $error("signed accumulate address did not set its mode");

    AST_FIRST_NO_START:
    assert property (hit_first && !s1_valid_q && !s2_valid_q
                     |=> !s1_valid_q ##1 !s2_valid_q ##1 $stable(res_q))
        else $error("first operand write started a computation");

    AST_SECOND_LAUNCH:
    assert property (hit_second |=> s1_valid_q ##1 s2_valid_q)
        else $error("second operand write did not launch");

    AST_THREE_CYCLES:
    assert property (hit_second && mode_q == PHM_UNSIGNED_PRODUCT
                     |-> ##3 ({res_q.high, res_q.low} ==
                              {16'h0000, $past(first_operand_q, 3)} *
                              {16'h0000, $past(second_val, 3)}))
        else $error("unsigned product not ready three cycles later");

    AST_SUM_EXT_ZERO:
    assert property (s2_valid_q && s2_mode_q == PHM_UNSIGNED_PRODUCT
                     |=> res_q.ext == 16'h0000)
        else $error("sum extension not zero after unsigned product");

    AST_SUM_EXT_SIGN:
    assert property (s2_valid_q && is_signed(s2_mode_q)
                     |=> res_q.ext == {16{res_q.high[15]}})
        else $error("sum extension does not follow the result sign");

    AST_SUM_EXT_CARRY:
    assert property (s2_valid_q && s2_mode_q == PHM_UNSIGNED_ACCUMULATE
                     |=> res_q.ext == {15'h0000, $past(sum[32])})
        else $error("sum extension does not hold the carry");

    AST_FIRST_PERSIST:
    assert property (!hit_first
                     |=> $stable(first_operand_q) && $stable(mode_q))
        else $error("first operand changed without a write");

    AST_BYTE_SIGN_EXT:
    assert property (wr && cpu_req_in.byte_acc &&
                     cpu_req_in.addr == `PHM_ADDR_SIGNED_PRODUCT
                     |=> first_operand_q[15:8] == {8{first_operand_q[7]}})
        else $error("signed byte operand not sign-extended");

    AST_ACCUMULATE:
    assert property (s2_valid_q && s2_mode_q == PHM_SIGNED_ACCUMULATE
                     |=> {res_q.high, res_q.low} ==
                         $past({res_q.high, res_q.low}) + $past(s2_prod_q))
        else $error("accumulate did not add product to held result");

endmodule : phm_top

// ===== verif/phm_cpu.sv
// CPU model issuing word and byte accesses to the hardware multiplier.
// Assumes the multiplier samples one access on each rising clock edge.
module phm_cpu (
    // Clock.
    input  wire logic         sys_clk_in,
    // Peripheral access and read data.
    output phm_pkg::phm_req_t cpu_req_out,
    input  wire logic [15:0]  cpu_rdata_in
);
    timeunit 1ns;
    timeprecision 100ps;
    import phm_pkg::*;

    initial cpu_req_out = '0;

    // Holds one access for one edge; the caller releases it with idle.
    task automatic access(input logic [15:0] a, input logic [15:0] d,
                          input logic w, input logic bt);
        cpu_req_out = '{addr: a, wdata: d, write: w, read: ~w, byte_acc: bt};
        @(posedge sys_clk_in);
        #1;
    endtask : access

    task automatic idle(input int n);
        cpu_req_out = '0;
        repeat (n) begin
            @(posedge sys_clk_in);
            #1;
        end
    endtask : idle

    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        access(a, 16'h0000, 1'b0, 1'b0);
        d = cpu_rdata_in;
    endtask : rd

    // Callers wait past the third edge after the launch before this.
    task automatic results(output logic [15:0] lo, output logic [15:0] hi,
                           output logic [15:0] ex);
        rd(16'h013a, lo);
        rd(16'h013c, hi);
        rd(16'h013e, ex);
        idle(1);
    endtask : results
endmodule : phm_cpu

// ===== verif/peripheral_hardware_multiplier_test.sv
// Self-checking bench for the hardware multiplier driven by a CPU model.
// Assumes phm_pkg, phm_top and phm_cpu are compiled before this file.
module peripheral_hardware_multiplier_test;
    timeunit 1ns;
    timeprecision 100ps;
    import phm_pkg::*;

    logic        sys_clk_in = 1'b0;
    logic        reset_in   = 1'b1;
    phm_req_t    cpu_req;
    logic [15:0] cpu_rdata;
    int          err_total  = 0;
    int          n_checks   = 0;
    logic [1:0]  mode_v     = 2'h0;
    logic [15:0] first_v    = 16'h0000;
    logic [31:0] res_v      = 32'h0000_0000;
    logic [15:0] ext_v      = 16'h0000;

    always #5 sys_clk_in = ~sys_clk_in;

    phm_top dut_u (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
                   .cpu_req_in(cpu_req), .cpu_rdata_out(cpu_rdata));
    phm_cpu cpu_u (.sys_clk_in(sys_clk_in), .cpu_req_out(cpu_req),
                   .cpu_rdata_in(cpu_rdata));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string what);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t %s: %h, expected %h", $time, what, seen, exp);
        end
    endtask : check

    function automatic logic [15:0] xt(logic [15:0] v, logic bt, logic sg);
        return !bt ? v : {{8{sg & v[7]}}, v[7:0]};
    endfunction : xt

    task automatic load1(input logic [1:0] m, input logic [15:0] a,
                         input logic bt);
        cpu_u.access(16'h0130 + {13'h0, m, 1'b0}, a, 1'b1, bt);
        mode_v = m;
        first_v = xt(a, bt, m[0]);
    endtask : load1

    task automatic preset(input logic [31:0] acc);
        cpu_u.access(16'h013a, acc[15:0], 1'b1, 1'b0);
        cpu_u.access(16'h013c, acc[31:16], 1'b1, 1'b0);
        res_v = acc;
    endtask : preset

    // Sign-extended operands give the two's complement product modulo 2^32.
    task automatic launch(input logic [15:0] b, input logic bt);
        logic [15:0] b16, lo, hi, ex, pre;
        logic [31:0] p;
        logic [32:0] s;
        b16 = xt(b, bt, mode_v[0]);
        p = {{16{mode_v[0] & first_v[15]}}, first_v}
            * {{16{mode_v[0] & b16[15]}}, b16};
        s = {1'b0, p} + (mode_v[1] ? {1'b0, res_v} : 33'h0);
        cpu_u.access(16'h0138, b, 1'b1, bt);
        cpu_u.idle(1);
        cpu_u.rd(16'h013a, pre);
        check(pre, res_v[15:0], "low word before third edge");
        cpu_u.results(lo, hi, ex);
        res_v = s[31:0];
        ext_v = mode_v[0] ? {16{s[31]}} : {15'h0, s[32] & mode_v[1]};
        check(lo, res_v[15:0], "low word");
        check(hi, res_v[31:16], "high word");
        check(ex, ext_v, "sum extension");
    endtask : launch

    // Every mode with every operand size, negative bytes included.
    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            for (int z = 0; z < 4; z++) begin
                preset(32'hfff0_8001 - 32'(z));
                load1(2'(m), 16'hfe85, z[1]);
                launch(16'h80c3, z[0]);
            end
        end
    endtask : t_modes

    // Chained accumulation, operand reuse, and register access kinds.
    task automatic t_persist();
        logic [15:0] v;
        preset(32'hffff_ffff);
        load1(2'd3, 16'h7fff, 1'b0);
        launch(16'h8000, 1'b0);
        launch(16'h8000, 1'b0);
        load1(2'd0, 16'hff85, 1'b1);
        cpu_u.idle(4);
        cpu_u.rd(16'h013a, v);
        check(v, res_v[15:0], "result after operand write");
        cpu_u.rd(16'h0136, v);
        check(v, 16'h0085, "operand readback");
        cpu_u.rd(16'h0140, v);
        check(v, 16'h0000, "unmapped read");
        cpu_u.access(16'h013e, 16'h1234, 1'b1, 1'b0);
        cpu_u.rd(16'h013e, v);
        check(v, ext_v, "sum extension after write");
        cpu_u.idle(1);
        launch(16'hff02, 1'b1);
        cpu_u.rd(16'h0138, v);
        check(v, 16'h0002, "second operand readback");
    endtask : t_persist

    task automatic final_report();
        $display("checks %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (6) @(posedge sys_clk_in);
        #1;
        reset_in = 1'b0;
        t_modes();
        t_persist();
        final_report();
    end
endmodule : peripheral_hardware_multiplier_test
